// >>> tb/retimer_status_control_regs_test.sv
`timescale 1ns/1ps
module retimer_status_control_regs_test;
	import retimer_regs_pkg::*;

	// ****************************************
	// Bench signals
	// ****************************************
	localparam logic [7:0] REV = 8'h3c; // Arbitrary revision code for this bench
	logic ref_clk;
	logic rst_n = 1'b0;
	reg_req_type reg_req = '0;
	logic [7:0] rd_data;
	logic rd_valid;
	logic pulse_enable_pin = 1'b0;
	logic clock_enable_pin = 1'b0;
	logic pulse_in_pin = 1'b0;
	analog_status_type analog_status = '0;
	adc_result_type adc_result = '0;
	logic temp_conversion_start;
	logic pulse_input_buffer_select;
	logic hold_monitor_latch_clear;
	logic hold_monitor_power_down;
	logic retimed_pulse_out;
	logic retime_clock_out;
	logic last_start;
	logic [7:0] v;
	int err_total = 0;
	int compares = 0;
	int base;
	int n;

	retimer_status_control_regs #(.DIE_REVISION_CODE(REV)) dut (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.reg_req(reg_req),
		.rd_data(rd_data),
		.rd_valid(rd_valid),
		.pulse_enable_pin(pulse_enable_pin),
		.clock_enable_pin(clock_enable_pin),
		.pulse_in_pin(pulse_in_pin),
		.analog_status(analog_status),
		.adc_result(adc_result),
		.temp_conversion_start(temp_conversion_start),
		.pulse_input_buffer_select(pulse_input_buffer_select),
		.hold_monitor_latch_clear(hold_monitor_latch_clear),
		.hold_monitor_power_down(hold_monitor_power_down),
		.retimed_pulse_out(retimed_pulse_out),
		.retime_clock_out(retime_clock_out)
	);

	// ****************************************
	// Clock and watchdog
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// The whole run needs a few thousand cycles; this bound is generous
	initial begin
		#200000;
		err_total++;
		$display("Error watchdog expected run end seen hang");
		end_of_test();
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Called at a falling edge; a spare cycle keeps strobes from being set twice in one step
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = d;
		@(negedge ref_clk);
		reg_req.wr = 1'b0;
		last_start = temp_conversion_start;
		@(negedge ref_clk);
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		@(negedge ref_clk);
		reg_req.rd = 1'b0;
		d = rd_data;
		check("read valid", {7'h00, rd_valid}, 8'h01);
		@(negedge ref_clk);
		check("read valid end", {7'h00, rd_valid}, 8'h00);
	endtask

	task automatic expect_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		check(what, d, exp);
	endtask

	// Pulse launched in a fixed phase of the output clock so the sample point never moves
	task automatic lat(input logic [7:0] cfg, output int cnt);
		wr_reg(ADDR_RETIME_EDGE, cfg);
		for (int i = 0; i < 4 && retime_clock_out !== 1'b0; i++) @(negedge ref_clk);
		pulse_in_pin = 1'b1;
		cnt = 0;
		while (retimed_pulse_out !== 1'b1 && cnt < 400) begin
			@(negedge ref_clk);
			cnt++;
		end
		pulse_in_pin = 1'b0;
		for (int i = 0; i < 400 && retimed_pulse_out !== 1'b0; i++) @(negedge ref_clk);
		// Drain the whole delay line so an old pulse can never reach a longer tap later
		repeat (OUT_CLK_CYCLES * (2 ** RETIME_DELAY_W) + HALF_OUT_CLK_CYCLES + 8) @(negedge ref_clk);
	endtask

	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (5) @(negedge ref_clk);
		rst_n = 1'b1;
		@(negedge ref_clk);
		// Reset values of the whole map, unmapped neighbours included
		for (int a = 8'h41; a <= 8'h55; a++) begin
			rd_reg(8'(a), v);
			check("reset value", v, (a == 8'h54) ? REV : 8'h00);
		end
		// Control bits to outputs, reserved bits stored
		wr_reg(ADDR_RETIMER_CTRL, 8'haf);
		check("ctrl outputs", {5'h00, hold_monitor_power_down, pulse_input_buffer_select, hold_monitor_latch_clear}, 8'h02);
		expect_reg("ctrl readback", ADDR_RETIMER_CTRL, 8'haf);
		wr_reg(ADDR_RETIMER_CTRL, 8'h50);
		check("ctrl outputs", {5'h00, hold_monitor_power_down, pulse_input_buffer_select, hold_monitor_latch_clear}, 8'h05);
		repeat (20) @(negedge ref_clk);
		check("clear held", {7'h00, hold_monitor_latch_clear}, 8'h01);
		wr_reg(ADDR_RSVD_SETTINGS_44, 8'ha5);
		expect_reg("reserved rw", ADDR_RSVD_SETTINGS_44, 8'ha5);
		// Writes to read-only places leave them unchanged
		for (int a = 8'h46; a <= 8'h55; a++) wr_reg(8'(a), 8'hff);
		wr_reg(8'h60, 8'hff);
		for (int a = 8'h46; a <= 8'h55; a++) begin
			rd_reg(8'(a), v);
			check("read only", v, (a == 8'h54) ? REV : 8'h00);
		end
		expect_reg("unmapped", 8'h60, 8'h00);
		// Second reset in mid-run brings settings back
		rst_n = 1'b0;
		repeat (2) @(negedge ref_clk);
		check("outputs in reset", {5'h00, hold_monitor_power_down, pulse_input_buffer_select, hold_monitor_latch_clear}, 8'h00);
		rst_n = 1'b1;
		@(negedge ref_clk);
		expect_reg("ctrl after reset", ADDR_RETIMER_CTRL, 8'h00);
		expect_reg("rsvd after reset", ADDR_RSVD_SETTINGS_44, 8'h00);
		// Status bits and readbacks
		pulse_enable_pin = 1'b1;
		clock_enable_pin = 1'b1;
		analog_status = '{locked: 1'b1, ref_good: 1'b1, cal_busy: 1'b1, monitor_pass: 1'b1, osc_core: 2'b10,
			osc_band: 8'ha5, osc_bias: 4'hc};
		repeat (8) @(negedge ref_clk);
		expect_reg("status all", ADDR_DEVICE_STATUS, 8'heb);
		expect_reg("osc core", ADDR_OSC_CORE, 8'h02);
		expect_reg("osc band", ADDR_OSC_BAND, 8'ha5);
		expect_reg("osc bias", ADDR_OSC_BIAS, 8'h0c);
		clock_enable_pin = 1'b0;
		analog_status = '{locked: 1'b0, ref_good: 1'b0, cal_busy: 1'b0, monitor_pass: 1'b1, osc_core: 2'b01,
			osc_band: 8'h5a, osc_bias: 4'h3};
		repeat (8) @(negedge ref_clk);
		expect_reg("status pulse pin", ADDR_DEVICE_STATUS, 8'ha0);
		expect_reg("osc core", ADDR_OSC_CORE, 8'h01);
		expect_reg("osc band", ADDR_OSC_BAND, 8'h5a);
		expect_reg("osc bias", ADDR_OSC_BIAS, 8'h03);
		pulse_enable_pin = 1'b0;
		clock_enable_pin = 1'b1;
		repeat (8) @(negedge ref_clk);
		expect_reg("status clock pin", ADDR_DEVICE_STATUS, 8'h60);
		// Monitor latch cleared by clear and by power-down
		wr_reg(ADDR_RETIMER_CTRL, 8'h10);
		expect_reg("status clear", ADDR_DEVICE_STATUS, 8'h40);
		wr_reg(ADDR_RETIMER_CTRL, 8'h00);
		repeat (3) @(negedge ref_clk);
		expect_reg("status released", ADDR_DEVICE_STATUS, 8'h60);
		wr_reg(ADDR_RETIMER_CTRL, 8'h40);
		expect_reg("status power down", ADDR_DEVICE_STATUS, 8'h40);
		wr_reg(ADDR_RETIMER_CTRL, 8'h00);
		clock_enable_pin = 1'b0;
		repeat (8) @(negedge ref_clk);
		// Temperature conversion, negative then positive result
		wr_reg(ADDR_CONV_START, 8'h01);
		check("start pulse", {7'h00, last_start}, 8'h01);
		check("start ends", {7'h00, temp_conversion_start}, 8'h00);
		expect_reg("busy", ADDR_DEVICE_STATUS, 8'h24);
		expect_reg("start readback", ADDR_CONV_START, 8'h01);
		adc_result = '{valid: 1'b1, sign: 1'b1, magnitude: 8'h37};
		@(negedge ref_clk);
		adc_result = '0;
		@(negedge ref_clk);
		expect_reg("busy done", ADDR_DEVICE_STATUS, 8'h20);
		expect_reg("temp magnitude", ADDR_TEMP_MAGNITUDE, 8'h37);
		expect_reg("temp sign", ADDR_TEMP_SIGN, 8'h01);
		wr_reg(ADDR_CONV_START, 8'hfe);
		check("no start", {7'h00, last_start}, 8'h00);
		expect_reg("start upper ro", ADDR_CONV_START, 8'h00);
		wr_reg(ADDR_CONV_START, 8'hff);
		check("start pulse", {7'h00, last_start}, 8'h01);
		expect_reg("start upper ro", ADDR_CONV_START, 8'h01);
		adc_result = '{valid: 1'b1, sign: 1'b0, magnitude: 8'h80};
		@(negedge ref_clk);
		adc_result = '0;
		@(negedge ref_clk);
		expect_reg("busy done", ADDR_DEVICE_STATUS, 8'h20);
		expect_reg("temp magnitude", ADDR_TEMP_MAGNITUDE, 8'h80);
		expect_reg("temp sign", ADDR_TEMP_SIGN, 8'h00);
		// Retimer latency: inverted edge adds one cycle, each delay step two
		lat(8'h80, base);
		check("base latency", {7'h00, (base >= 4 && base <= 8)}, 8'h01);
		lat(8'h00, n);
		check("inverted edge", 8'(n - base), 8'd1);
		lat(8'h83, n);
		check("delay three", 8'(n - base), 8'd6);
		lat(8'h7f, n);
		check("delay max", 8'(n - base), 8'd255);
		expect_reg("edge readback", ADDR_RETIME_EDGE, 8'h7f);
		v[0] = retime_clock_out;
		@(negedge ref_clk);
		check("output clock", {7'h00, retime_clock_out}, {7'h00, ~v[0]});
		end_of_test();
	end
endmodule

// >>> verilog/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3
	import retimer_regs_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic pin,
	output logic level
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} sync_type;

	sync_type s;
	sync_type next_s;

	// Only s2 and s3 are compared; s1 may be metastable
	always_comb begin
		next_s = s;
		next_s.s1 = pin;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		if (s.s2 == s.s3) begin
			next_s.level = s.s2;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign level = s.level;

	a_sync_agree: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(s.level != $past(s.level)) |-> ($past(s.s2) == $past(s.s3)))
		else $error("synchronised level changed without agreement");

endmodule

// >>> verilog/pulse_retimer.sv
`timescale 1ns/1ps
module pulse_retimer
	import retimer_regs_pkg::*;
#(
	parameter int DELAY_W = RETIME_DELAY_W
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic pulse_in,
	input wire logic edge_invert,
	input wire logic [DELAY_W-1:0] delay,
	output logic pulse_out,
	output logic clock_out
);

	localparam int TAPS = OUT_CLK_CYCLES * (2 ** DELAY_W) + HALF_OUT_CLK_CYCLES;

	generate
		if (DELAY_W < 1 || DELAY_W > 8) begin : g_bad_width
			$error("pulse_retimer: DELAY_W must lie in 1..8");
		end
	endgenerate

	typedef struct packed {
		logic phase;
		logic sample;
		logic [TAPS-1:0] line;
		logic pulse_out;
	} retimer_type;

	retimer_type s;
	retimer_type next_s;
	logic [DELAY_W+1:0] tap;

	// ****************************************
	// Retiming and delay line
	// ****************************************
	// The output clock runs at half the ref clock, so half its period is one cycle
	always_comb begin
		next_s = s;
		tap = (DELAY_W+2)'(OUT_CLK_CYCLES) * {2'b00, delay} + (DELAY_W+2)'(edge_invert ? HALF_OUT_CLK_CYCLES : 0);
		next_s.phase = ~s.phase;
		if (!s.phase) begin
			next_s.sample = pulse_in;
		end
		next_s.line = {s.line[TAPS-2:0], s.sample};
		next_s.pulse_out = s.line[tap];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign pulse_out = s.pulse_out;
	assign clock_out = s.phase;

endmodule

// >>> verilog/retimer_regs_pkg.sv
package retimer_regs_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] ADDR_RETIMER_CTRL = 8'h42;
	localparam logic [7:0] ADDR_RETIME_EDGE = 8'h43;
	localparam logic [7:0] ADDR_RSVD_SETTINGS_44 = 8'h44;
	localparam logic [7:0] ADDR_CONV_START = 8'h45;
	localparam logic [7:0] ADDR_RSVD_READBACK_LOW = 8'h46;
	localparam logic [7:0] ADDR_RSVD_READBACK_MID = 8'h47;
	localparam logic [7:0] ADDR_RSVD_READBACK_HIGH = 8'h48;
	localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h49;
	localparam logic [7:0] ADDR_RSVD_STATUS_4A = 8'h4a;
	localparam logic [7:0] ADDR_OSC_CORE = 8'h4b;
	localparam logic [7:0] ADDR_TEMP_MAGNITUDE = 8'h4c;
	localparam logic [7:0] ADDR_TEMP_SIGN = 8'h4d;
	localparam logic [7:0] ADDR_RSVD_STATUS_4E = 8'h4e;
	localparam logic [7:0] ADDR_OSC_BAND = 8'h4f;
	localparam logic [7:0] ADDR_RSVD_STATUS_50 = 8'h50;
	localparam logic [7:0] ADDR_OSC_BIAS = 8'h51;
	localparam logic [7:0] ADDR_RSVD_STATUS_52 = 8'h52;
	localparam logic [7:0] ADDR_RSVD_STATUS_53 = 8'h53;
	localparam logic [7:0] ADDR_DIE_REVISION = 8'h54;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int BIT_MON_POWER_DOWN = 6;
	localparam int BIT_BUFFER_SELECT = 5;
	localparam int BIT_MON_CLEAR = 4;
	localparam int BIT_EDGE_SELECT = 7;
	localparam int RETIME_DELAY_W = 7;
	localparam int BIT_CONV_START = 0;
	localparam int BIT_ST_PULSE_EN = 7;
	localparam int BIT_ST_CLOCK_EN = 6;
	localparam int BIT_ST_TIMING_GOOD = 5;
	localparam int BIT_ST_REF_GOOD = 3;
	localparam int BIT_ST_ADC_BUSY = 2;
	localparam int BIT_ST_CAL_BUSY = 1;
	localparam int BIT_ST_LOCKED = 0;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0] RESET_RETIMER_CTRL = 8'h00;
	localparam logic [7:0] RESET_RETIME_EDGE = 8'h00;
	localparam logic [7:0] RESET_RSVD_SETTINGS = 8'h00;
	localparam logic [8:0] RESET_TEMPERATURE = 9'h000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int REF_CLK_PERIOD_NS = 4;
	localparam int OUT_CLK_PERIOD_NS = 8;
	localparam int OUT_CLK_CYCLES = OUT_CLK_PERIOD_NS / REF_CLK_PERIOD_NS;
	localparam int HALF_OUT_CLK_CYCLES = (OUT_CLK_PERIOD_NS / 2) / REF_CLK_PERIOD_NS;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic {ADC_IDLE, ADC_BUSY} adc_state_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_type;

	typedef struct packed {
		logic locked;
		logic ref_good;
		logic cal_busy;
		logic monitor_pass;
		logic [1:0] osc_core;
		logic [7:0] osc_band;
		logic [3:0] osc_bias;
	} analog_status_type;

	typedef struct packed {
		logic valid;
		logic sign;
		logic [7:0] magnitude;
	} adc_result_type;

endpackage

// >>> verilog/retimer_status_control_regs.sv
`timescale 1ns/1ps
module retimer_status_control_regs
	import retimer_regs_pkg::*;
#(
	parameter logic [7:0] DIE_REVISION_CODE = 8'h5a // Arbitrary value
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire reg_req_type reg_req,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic pulse_enable_pin,
	input wire logic clock_enable_pin,
	input wire logic pulse_in_pin,
	input wire analog_status_type analog_status,
	input wire adc_result_type adc_result,
	output logic temp_conversion_start,
	output logic pulse_input_buffer_select,
	output logic hold_monitor_latch_clear,
	output logic hold_monitor_power_down,
	output logic retimed_pulse_out,
	output logic retime_clock_out
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] retime;
		logic [7:0] rsvd44;
		logic start_bit;
		logic start_pulse;
		adc_state_type adc_state;
		logic [8:0] temperature;
		logic timing_latch;
		logic [7:0] rd_data;
		logic rd_valid;
	} regs_type;

	regs_type s;
	regs_type next_s;

	logic pulse_enable_pin_state;
	logic clock_enable_pin_state;
	logic pulse_sync;
	logic [7:0] status_byte;
	logic [7:0] read_value;
	logic write_ctrl;
	logic write_retime;
	logic write_start;
	logic start_request;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	pin_sync3 u_sync_pulse_enable (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin(pulse_enable_pin),
		.level(pulse_enable_pin_state)
	);

	pin_sync3 u_sync_clock_enable (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin(clock_enable_pin),
		.level(clock_enable_pin_state)
	);

	pin_sync3 u_sync_pulse (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin(pulse_in_pin),
		.level(pulse_sync)
	);

	// ****************************************
	// Pulse retimer
	// ****************************************
	// Field value 0 means inverted, so the invert input is the complement
	pulse_retimer #(
		.DELAY_W(RETIME_DELAY_W)
	) u_retimer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pulse_in(pulse_sync),
		.edge_invert(~s.retime[BIT_EDGE_SELECT]),
		.delay(s.retime[RETIME_DELAY_W-1:0]),
		.pulse_out(retimed_pulse_out),
		.clock_out(retime_clock_out)
	);

	// ****************************************
	// Write decode
	// ****************************************
	assign write_ctrl = reg_req.wr && (reg_req.addr == ADDR_RETIMER_CTRL);
	assign write_retime = reg_req.wr && (reg_req.addr == ADDR_RETIME_EDGE);
	assign write_start = reg_req.wr && (reg_req.addr == ADDR_CONV_START);
	assign start_request = write_start && reg_req.wdata[BIT_CONV_START];

	// ****************************************
	// Status byte
	// ****************************************
	// Bit 4 is reserved and reads zero
	always_comb begin
		status_byte = 8'h00;
		status_byte[BIT_ST_PULSE_EN] = pulse_enable_pin_state;
		status_byte[BIT_ST_CLOCK_EN] = clock_enable_pin_state;
		status_byte[BIT_ST_TIMING_GOOD] = s.timing_latch;
		status_byte[BIT_ST_REF_GOOD] = analog_status.ref_good;
		status_byte[BIT_ST_ADC_BUSY] = (s.adc_state == ADC_BUSY);
		status_byte[BIT_ST_CAL_BUSY] = analog_status.cal_busy;
		status_byte[BIT_ST_LOCKED] = analog_status.locked;
	end

	// ****************************************
	// Read mux
	// ****************************************
	// Unmapped and reserved read-only addresses answer zero
	always_comb begin
		read_value = 8'h00;
		case (reg_req.addr)
			ADDR_RETIMER_CTRL: begin
				read_value = s.ctrl;
			end
			ADDR_RETIME_EDGE: begin
				read_value = s.retime;
			end
			ADDR_RSVD_SETTINGS_44: begin
				read_value = s.rsvd44;
			end
			ADDR_CONV_START: begin
				read_value = {7'h00, s.start_bit};
			end
			ADDR_DEVICE_STATUS: begin
				read_value = status_byte;
			end
			ADDR_OSC_CORE: begin
				read_value = {6'h00, analog_status.osc_core};
			end
			ADDR_TEMP_MAGNITUDE: begin
				read_value = s.temperature[7:0];
			end
			ADDR_TEMP_SIGN: begin
				read_value = {7'h00, s.temperature[8]};
			end
			ADDR_OSC_BAND: begin
				read_value = analog_status.osc_band;
			end
			ADDR_OSC_BIAS: begin
				read_value = {4'h0, analog_status.osc_bias};
			end
			ADDR_DIE_REVISION: begin
				read_value = DIE_REVISION_CODE;
			end
			default: begin
				read_value = 8'h00;
			end
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		next_s = s;
		next_s.start_pulse = 1'b0;
		next_s.rd_valid = reg_req.rd;
		if (reg_req.rd) begin
			next_s.rd_data = read_value;
		end
		// Reserved bits of the control register store whatever is written
		if (write_ctrl) begin
			next_s.ctrl = reg_req.wdata;
		end
		if (write_retime) begin
			next_s.retime = reg_req.wdata;
		end
		if (reg_req.wr && (reg_req.addr == ADDR_RSVD_SETTINGS_44)) begin
			next_s.rsvd44 = reg_req.wdata;
		end
		if (write_start) begin
			next_s.start_bit = reg_req.wdata[BIT_CONV_START];
		end
		// A result always lands in the temperature registers
		if (adc_result.valid) begin
			next_s.temperature = {adc_result.sign, adc_result.magnitude};
		end
		// Busy state; a new start beats a completing result in the same cycle
		case (s.adc_state)
			ADC_IDLE: begin
				if (start_request) begin
					next_s.adc_state = ADC_BUSY;
					next_s.start_pulse = 1'b1;
				end
			end
			ADC_BUSY: begin
				if (start_request) begin
					next_s.start_pulse = 1'b1;
				end else if (adc_result.valid) begin
					next_s.adc_state = ADC_IDLE;
				end
			end
			default: begin
				next_s.adc_state = ADC_IDLE;
			end
		endcase
		// Monitor latch: clear or power-down dominate a passing check
		if (s.ctrl[BIT_MON_CLEAR] || s.ctrl[BIT_MON_POWER_DOWN]) begin
			next_s.timing_latch = 1'b0;
		end else if (analog_status.monitor_pass) begin
			next_s.timing_latch = 1'b1;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s.ctrl <= RESET_RETIMER_CTRL;
			s.retime <= RESET_RETIME_EDGE;
			s.rsvd44 <= RESET_RSVD_SETTINGS;
			s.start_bit <= 1'b0;
			s.start_pulse <= 1'b0;
			s.adc_state <= ADC_IDLE;
			s.temperature <= RESET_TEMPERATURE;
			s.timing_latch <= 1'b0;
			s.rd_data <= 8'h00;
			s.rd_valid <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rd_data = s.rd_data;
	assign rd_valid = s.rd_valid;
	assign temp_conversion_start = s.start_pulse;
	assign pulse_input_buffer_select = s.ctrl[BIT_BUFFER_SELECT];
	assign hold_monitor_latch_clear = s.ctrl[BIT_MON_CLEAR];
	assign hold_monitor_power_down = s.ctrl[BIT_MON_POWER_DOWN];

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_buffer_select_write: assert property (
		write_ctrl |=> (pulse_input_buffer_select == $past(reg_req.wdata[BIT_BUFFER_SELECT])))
		else $error("buffer select did not follow the write");

	a_monitor_clear_hold: assert property (
		(hold_monitor_latch_clear && !write_ctrl) |=> (!hold_monitor_latch_clear || !s.timing_latch))
		else $error("monitor latch not held clear");

	a_clear_not_self: assert property (
		(hold_monitor_latch_clear && !write_ctrl) |=> hold_monitor_latch_clear)
		else $error("monitor clear bit cleared itself");

	a_retime_write: assert property (
		write_retime |=> (s.retime == $past(reg_req.wdata)))
		else $error("retiming register did not store the write");

	a_start_busy: assert property (
		start_request |=> (temp_conversion_start && s.adc_state == ADC_BUSY))
		else $error("conversion start did not raise busy");

	a_busy_falls: assert property (
		(s.adc_state == ADC_BUSY && adc_result.valid && !start_request)
		|=> (s.adc_state == ADC_IDLE && s.temperature == $past({adc_result.sign, adc_result.magnitude})))
		else $error("busy did not fall with stored result");

	a_status_read: assert property (
		(reg_req.rd && reg_req.addr == ADDR_DEVICE_STATUS) |=> (rd_valid && rd_data == $past(status_byte)))
		else $error("status read returned wrong value");

	a_reserved_zero: assert property (
		(reg_req.rd && (reg_req.addr == ADDR_RSVD_READBACK_LOW || reg_req.addr == ADDR_RSVD_STATUS_53))
		|=> (rd_data == 8'h00))
		else $error("reserved register read not zero");

	a_power_down_latch: assert property (
		(hold_monitor_power_down && !write_ctrl) ##1 hold_monitor_power_down |=> !s.timing_latch)
		else $error("monitor latch set while powered down");

	a_read_valid_pulse: assert property (
		reg_req.rd |=> rd_valid)
		else $error("read request gave no valid strobe");

	a_read_valid_end: assert property (
		!reg_req.rd |=> !rd_valid)
		else $error("valid strobe without a read request");

	a_start_single: assert property (
		(temp_conversion_start && !start_request) |=> !temp_conversion_start)
		else $error("conversion start pulse stretched");

	a_sign_upper_zero: assert property (
		(reg_req.rd && reg_req.addr == ADDR_TEMP_SIGN) |=> (rd_data[7:1] == 7'h00))
		else $error("temperature sign upper bits not zero");

	a_core_upper_zero: assert property (
		(reg_req.rd && reg_req.addr == ADDR_OSC_CORE) |=> (rd_data[7:2] == 6'h00))
		else $error("core readback upper bits not zero");

	a_bias_upper_zero: assert property (
		(reg_req.rd && reg_req.addr == ADDR_OSC_BIAS) |=> (rd_data[7:4] == 4'h0))
		else $error("bias readback upper bits not zero");

	a_ctrl_kept: assert property (
		!write_ctrl |=> (s.ctrl == $past(s.ctrl)))
		else $error("control register changed without a write");

	c_conversion_done: cover property (start_request ##[1:50] (adc_result.valid && s.adc_state == ADC_BUSY));
	c_status_read: cover property (reg_req.rd && reg_req.addr == ADDR_DEVICE_STATUS);
	c_latch_set: cover property (!s.timing_latch ##1 s.timing_latch);
	c_clear_release: cover property (hold_monitor_latch_clear ##1 !hold_monitor_latch_clear);

endmodule
